// ===== rtl/timer8_map.vh
// Register offsets, field positions and reset values of the 8-bit timer
`ifndef TIMER8_MAP_VH
`define TIMER8_MAP_VH
// ----------------------------------------
// Register offsets
// ----------------------------------------
`define COUNT_VALUE_ADDR 8'hca
`define TIMER_CONTROL_ADDR 8'hcb
`define CHANNEL0_CONTROL_ADDR 8'hcc
`define CHANNEL0_COMPARE_ADDR 8'hcd
`define CHANNEL1_CONTROL_ADDR 8'hce
`define CHANNEL1_COMPARE_ADDR 8'hcf
`define TIMER_FLAGS_ADDR 8'hd8
// ----------------------------------------
// Timer control fields
// ----------------------------------------
`define TCTL_DIV_HI 7
`define TCTL_DIV_LO 5
`define TCTL_START_BIT 4
`define TCTL_WRAP_MASK_BIT 3
`define TCTL_ZERO_STROBE_BIT 2
`define TCTL_MODE_HI 1
`define TCTL_MODE_LO 0
`define TCTL_RESET 8'h08
// ----------------------------------------
// Channel control fields
// ----------------------------------------
`define CCTL_IRQ_MASK_BIT 6
`define CCTL_ACTION_HI 5
`define CCTL_ACTION_LO 3
`define CCTL_ENABLE_BIT 2
`define CCTL_RESET 8'h40
`define CCTL_WRITE_MASK 8'h7f
`define COMPARE_RESET 8'h00
// ----------------------------------------
// Modes and output actions
// ----------------------------------------
`define MODE_FREE 2'h0
`define MODE_DOWN 2'h1
`define MODE_MODULO 2'h2
`define MODE_UPDOWN 2'h3
`define ACT_SET 3'h0
`define ACT_CLEAR 3'h1
`define ACT_TOGGLE 3'h2
`define ACT_SET_UP 3'h3
`define ACT_CLR_UP 3'h4
`define ACT_SET_CMP 3'h5
`define ACT_CLR_CMP 3'h6
`endif

// ===== rtl/compare_channel.v
// One compare channel: match detection and output pin action
`timescale 1ns/10ps
`include "timer8_map.vh"
module compare_channel
(
	input wire sys_clk,
	input wire reset_n,
	input wire tick,
	input wire running,
	input wire [7:0] count_byte,
	input wire count_down,
	input wire updown_mode,
	input wire [7:0] match_level,
	input wire [7:0] second_level,
	input wire [2:0] output_action,
	input wire compare_enable,
	output wire compare_hit,
	output reg pin_out
);
	wire at_zero;
	wire at_second;

	// Match only counts on an active edge of a running timer
	assign compare_hit = tick & running & (count_byte == match_level);
	assign at_zero = tick & running & (count_byte == 8'h00);
	assign at_second = tick & running & (count_byte == second_level);

	// ----------------------------------------
	// Output action
	// ----------------------------------------
	// Compare checked first, so it wins over a secondary event in the same cycle
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			pin_out <= 1'b0;
		else if (compare_enable)
		begin
			case (output_action)
			`ACT_SET: if (compare_hit) pin_out <= 1'b1;
			`ACT_CLEAR: if (compare_hit) pin_out <= 1'b0;
			`ACT_TOGGLE: if (compare_hit) pin_out <= ~pin_out;
			`ACT_SET_UP:
			begin
				if (compare_hit)
					pin_out <= !count_down;
				else if (at_zero && !updown_mode)
					pin_out <= 1'b0;
			end
			`ACT_CLR_UP:
			begin
				if (compare_hit)
					pin_out <= count_down;
				else if (at_zero && !updown_mode)
					pin_out <= 1'b1;
			end
			`ACT_SET_CMP:
			begin
				if (compare_hit)
					pin_out <= 1'b1;
				else if (at_second)
					pin_out <= 1'b0;
			end
			`ACT_CLR_CMP:
			begin
				if (compare_hit)
					pin_out <= 1'b0;
				else if (at_second)
					pin_out <= 1'b1;
			end
			default: pin_out <= pin_out; // Unused code holds the pin
			endcase
		end
	end
endmodule // compare_channel

// ===== rtl/timer8_two_channel.v
// Eight-bit timer with prescaler, four count modes and two compare channels
//
// Chosen here: strobed register access.
`timescale 1ns/10ps
`include "timer8_map.vh"
module timer8_two_channel
(
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	input wire irq_enable_one,
	input wire sleep_wake,
	output wire channel0_out,
	output wire channel1_out,
	output wire timer_flag,
	output wire timer_irq
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	localparam DIR_UP = 1'b0;
	localparam DIR_DOWN = 1'b1;

	reg [7:0] ctrl_q;
	reg [7:0] cctl0_q;
	reg [7:0] cctl1_q;
	reg [7:0] cmp0_shadow_q;
	reg [7:0] cmp0_q;
	reg [7:0] cmp1_q;
	reg [7:0] count_q;
	reg [7:0] count_d;
	reg dir_q;
	reg dir_d;
	reg [6:0] presc_q;
	reg start_q;
	reg wrap_flag_q;
	reg ch0_flag_q;
	reg ch1_flag_q;
	reg wrap_event;
	reg wake_meta_q;
	reg wake_q;
	wire [7:0] ch0_undo_level;
	wire [1:0] mode;
	wire [2:0] div_sel;
	wire tick;
	wire running;
	wire ch0_hit;
	wire ch1_hit;
	wire ch0_event;
	wire zero_strobe;
	wire [7:0] flags_rd;

	assign mode = ctrl_q[`TCTL_MODE_HI:`TCTL_MODE_LO];
	assign div_sel = ctrl_q[`TCTL_DIV_HI:`TCTL_DIV_LO];
	assign running = ctrl_q[`TCTL_START_BIT];
	assign zero_strobe = reg_write && (reg_addr == `TIMER_CONTROL_ADDR) &&
		reg_wdata[`TCTL_ZERO_STROBE_BIT];

	// Divider tap: ratio 2^sel, so sel 0 gives a tick every cycle
	function tap_hit;
		input [2:0] sel;
		input [6:0] cnt;
		reg [6:0] lowmask;
		begin
			lowmask = (7'h01 << sel) - 7'h01;
			tap_hit = ((cnt & lowmask) == 7'h00);
		end
	endfunction

	// ----------------------------------------
	// Prescaler
	// ----------------------------------------
	// Free running, so a new selection takes effect on the next tap
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			presc_q <= 7'h00;
		else
			presc_q <= presc_q + 7'h01;
	end

	assign tick = tap_hit(div_sel, presc_q);

	// ----------------------------------------
	// Wake synchroniser
	// ----------------------------------------
	// Wake level comes from the power controller, so two flops first
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			wake_meta_q <= 1'b0;
			wake_q <= 1'b0;
		end
		else
		begin
			wake_meta_q <= sleep_wake;
			wake_q <= wake_meta_q;
		end
	end

	// ----------------------------------------
	// Register writes
	// ----------------------------------------
	// Strobe bit is never stored; sleep exit also leaves it low
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			ctrl_q <= `TCTL_RESET;
			cctl0_q <= `CCTL_RESET;
			cctl1_q <= `CCTL_RESET;
			cmp0_shadow_q <= `COMPARE_RESET;
			cmp1_q <= `COMPARE_RESET;
		end
		else if (reg_write)
		begin
			case (reg_addr)
			`TIMER_CONTROL_ADDR:
				ctrl_q <= reg_wdata & ~(8'h01 << `TCTL_ZERO_STROBE_BIT);
			`CHANNEL0_CONTROL_ADDR:
				cctl0_q <= reg_wdata & `CCTL_WRITE_MASK;
			`CHANNEL0_COMPARE_ADDR:
				cmp0_shadow_q <= reg_wdata;
			`CHANNEL1_CONTROL_ADDR:
				cctl1_q <= reg_wdata & `CCTL_WRITE_MASK;
			`CHANNEL1_COMPARE_ADDR:
				cmp1_q <= reg_wdata;
			default: ctrl_q <= ctrl_q;
			endcase
		end
		else if (wake_q)
			ctrl_q[`TCTL_ZERO_STROBE_BIT] <= 1'b0;
	end

	// Channel 0 compare only moves over while the counter sits at zero
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			cmp0_q <= `COMPARE_RESET;
		else if (count_q == 8'h00)
			cmp0_q <= cmp0_shadow_q;
	end

	// ----------------------------------------
	// Counter next state
	// ----------------------------------------
	always @*
	begin
		count_d = count_q;
		dir_d = dir_q;
		wrap_event = 1'b0;
		if (running && tick)
		begin
			case (mode)
			`MODE_FREE:
			begin
				count_d = count_q + 8'h01;
				wrap_event = (count_q == 8'hff);
			end
			`MODE_DOWN:
			begin
				if (count_q != 8'h00)
					count_d = count_q - 8'h01;
				wrap_event = (count_q == 8'h01);
			end
			`MODE_MODULO:
			begin
				if (count_q == cmp0_q)
					count_d = 8'h00;
				else
					count_d = count_q + 8'h01;
				wrap_event = (count_q == cmp0_q);
			end
			default:
			begin
				// Up/down turns round at compare value and at zero
				if (dir_q == DIR_UP && count_q == cmp0_q)
				begin
					dir_d = DIR_DOWN;
					count_d = count_q - 8'h01;
				end
				else if (dir_q == DIR_DOWN && count_q == 8'h00)
				begin
					dir_d = DIR_UP;
					count_d = count_q + 8'h01;
				end
				else if (dir_q == DIR_UP)
					count_d = count_q + 8'h01;
				else
					count_d = count_q - 8'h01;
				wrap_event = (dir_q == DIR_DOWN) && (count_q == 8'h00);
			end
			endcase
		end
	end

	// ----------------------------------------
	// Counter register
	// ----------------------------------------
	// Down mode loads on the start edge; clear strobe beats everything
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			count_q <= 8'h00;
			dir_q <= DIR_UP;
			start_q <= 1'b0;
		end
		else
		begin
			start_q <= running;
			if (zero_strobe)
			begin
				count_q <= 8'h00;
				dir_q <= DIR_UP;
			end
			else if (mode == `MODE_DOWN && running && !start_q)
				count_q <= cmp0_shadow_q;
			else
			begin
				count_q <= count_d;
				dir_q <= (mode == `MODE_UPDOWN) ? dir_d : DIR_UP;
			end
		end
	end

	// ----------------------------------------
	// Compare channels
	// ----------------------------------------
	// Channel 0 undo point: 0xff for action 101, zero for action 110
	assign ch0_undo_level = (cctl0_q[`CCTL_ACTION_HI:`CCTL_ACTION_LO] ==
		`ACT_CLR_CMP) ? 8'h00 : 8'hff;

	compare_channel u_ch0
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.tick(tick),
		.running(running),
		.count_byte(count_q),
		.count_down(dir_q),
		.updown_mode(mode == `MODE_UPDOWN),
		.match_level(cmp0_q),
		.second_level(ch0_undo_level),
		.output_action(cctl0_q[`CCTL_ACTION_HI:`CCTL_ACTION_LO]),
		.compare_enable(cctl0_q[`CCTL_ENABLE_BIT]),
		.compare_hit(ch0_hit),
		.pin_out(channel0_out)
	);

	compare_channel u_ch1
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.tick(tick),
		.running(running),
		.count_byte(count_q),
		.count_down(dir_q),
		.updown_mode(mode == `MODE_UPDOWN),
		.match_level(cmp1_q),
		.second_level(cmp0_q),
		.output_action(cctl1_q[`CCTL_ACTION_HI:`CCTL_ACTION_LO]),
		.compare_enable(cctl1_q[`CCTL_ENABLE_BIT]),
		.compare_hit(ch1_hit),
		.pin_out(channel1_out)
	);

	// In up/down mode channel 0 flags the turn at zero instead
	assign ch0_event = (mode == `MODE_UPDOWN) ? wrap_event : ch0_hit;

	// ----------------------------------------
	// Event flags
	// ----------------------------------------
	// Write one to clear; a new event in the same cycle wins
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			wrap_flag_q <= 1'b0;
			ch0_flag_q <= 1'b0;
			ch1_flag_q <= 1'b0;
		end
		else
		begin
			if (wrap_event)
				wrap_flag_q <= 1'b1;
			else if (reg_write && reg_addr == `TIMER_FLAGS_ADDR && reg_wdata[0])
				wrap_flag_q <= 1'b0;
			if (ch0_event)
				ch0_flag_q <= 1'b1;
			else if (reg_write && reg_addr == `TIMER_FLAGS_ADDR && reg_wdata[1])
				ch0_flag_q <= 1'b0;
			if (ch1_hit)
				ch1_flag_q <= 1'b1;
			else if (reg_write && reg_addr == `TIMER_FLAGS_ADDR && reg_wdata[2])
				ch1_flag_q <= 1'b0;
		end
	end

	// Masks gate flags onto the cpu flag; request also needs enable
	assign timer_flag = (wrap_flag_q & ctrl_q[`TCTL_WRAP_MASK_BIT]) |
		(ch0_flag_q & cctl0_q[`CCTL_IRQ_MASK_BIT]) |
		(ch1_flag_q & cctl1_q[`CCTL_IRQ_MASK_BIT]);
	assign timer_irq = timer_flag & irq_enable_one;

	assign flags_rd = {5'h00, ch1_flag_q, ch0_flag_q, wrap_flag_q};

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Data valid only the cycle after the strobe, zero otherwise
	always @(posedge sys_clk)
	begin
		if (!reset_n)
			reg_rdata <= 8'h00;
		else if (reg_read)
		begin
			case (reg_addr)
			`COUNT_VALUE_ADDR: reg_rdata <= count_q;
			`TIMER_CONTROL_ADDR: reg_rdata <= ctrl_q;
			`CHANNEL0_CONTROL_ADDR: reg_rdata <= cctl0_q;
			`CHANNEL0_COMPARE_ADDR: reg_rdata <= cmp0_shadow_q;
			`CHANNEL1_CONTROL_ADDR: reg_rdata <= cctl1_q;
			`CHANNEL1_COMPARE_ADDR: reg_rdata <= cmp1_q;
			`TIMER_FLAGS_ADDR: reg_rdata <= flags_rd;
			default: reg_rdata <= 8'h00;
			endcase
		end
		else
			reg_rdata <= 8'h00;
	end
endmodule // timer8_two_channel

// ===== sim/timer8_properties.sv
// Concurrent checks on the ports of the two-channel timer
`timescale 1ns/10ps
module timer8_checker
(
	input wire sys_clk,
	input wire reset_n,
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	input wire [7:0] reg_rdata,
	input wire irq_enable_one,
	input wire channel0_out,
	input wire channel1_out,
	input wire timer_flag,
	input wire timer_irq
);
	// Accesses that the checks key on
	wire wr_ctl = reg_write && reg_addr == 8'hcb;
	wire rd_cnt = reg_read && reg_addr == 8'hca;
	logic en0_q;
	logic en1_q;
	default clocking main_cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// Enable bits mirrored, since the body is hidden from us
	always @(posedge sys_clk)
	begin
		if (!reset_n)
		begin
			en0_q <= 1'b0;
			en1_q <= 1'b0;
		end
		else if (reg_write && reg_addr == 8'hcc)
			en0_q <= reg_wdata[2];
		else if (reg_write && reg_addr == 8'hce)
			en1_q <= reg_wdata[2];
	end
	// Port relations
	a_irq_gated: assert property (
		timer_irq == (timer_flag && irq_enable_one))
		else $error("irq output differs from flag and enable");
	a_strobe_low: assert property (
		reg_read && reg_addr == 8'hcb |=> !reg_rdata[2])
		else $error("clear bit read back as one");
	a_clear_zero: assert property (
		wr_ctl && reg_wdata[2] && !reg_wdata[4] ##1 rd_cnt
		|=> reg_rdata == 8'h00)
		else $error("count not zero after clear");
	a_stop_holds: assert property (
		wr_ctl && !reg_wdata[4] ##1 rd_cnt [*2]
		|=> reg_rdata == $past(reg_rdata))
		else $error("stopped count moved");
	a_free_steps: assert property (
		wr_ctl && reg_wdata[7:4] == 4'h1 && reg_wdata[2:0] == 3'h0
		##1 rd_cnt [*2] |=> reg_rdata - $past(reg_rdata) == 8'h01)
		else $error("free count did not step by one");
	a_pin0_off: assert property (
		!en0_q |=> $stable(channel0_out))
		else $error("disabled channel 0 pin changed");
	a_pin1_off: assert property (
		!en1_q |=> $stable(channel1_out))
		else $error("disabled channel 1 pin changed");
	a_cmp1_now: assert property (
		reg_write && reg_addr == 8'hcf ##1 reg_read && reg_addr == 8'hcf
		|=> reg_rdata == $past(reg_wdata, 2))
		else $error("channel 1 compare not written at once");
	c_irq: cover property (timer_irq);
	c_pin0: cover property ($rose(channel0_out));
	c_pin1: cover property ($rose(channel1_out));
endmodule // timer8_checker
bind timer8_two_channel timer8_checker timer8_checker_i
(
	.sys_clk(sys_clk),
	.reset_n(reset_n),
	.reg_addr(reg_addr),
	.reg_wdata(reg_wdata),
	.reg_write(reg_write),
	.reg_read(reg_read),
	.reg_rdata(reg_rdata),
	.irq_enable_one(irq_enable_one),
	.channel0_out(channel0_out),
	.channel1_out(channel1_out),
	.timer_flag(timer_flag),
	.timer_irq(timer_irq)
);

// ===== sim/tb_top.sv
// Self-checking bench for the two-channel 8-bit timer
`timescale 1ns/10ps
module tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [7:0] reg_wdata = 8'h00;
	logic reg_write = 1'b0;
	logic reg_read = 1'b0;
	logic irq_enable_one = 1'b0;
	logic sleep_wake = 1'b0;
	wire [7:0] reg_rdata;
	wire channel0_out;
	wire channel1_out;
	wire timer_flag;
	wire timer_irq;
	logic [7:0] exp_now = 8'h00;
	logic [7:0] msk_now = 8'h00;
	logic [7:0] exp_due = 8'h00;
	logic [7:0] msk_due = 8'h00;
	logic [7:0] adr_due = 8'h00;
	logic rd_due = 1'b0;
	int error_cnt = 0;
	int check_count = 0;
	// Reset values; rows hold mode, channel, control, high cycles
	logic [7:0] ra [8] = '{8'hcb,8'hcc,8'hcd,8'hce,8'hcf,8'hca,8'hd8,8'h00};
	logic [7:0] rv [8] = '{8'h08,8'h40,8'h00,8'h40,8'h00,8'h00,8'h00,8'h00};
	logic [31:0] rows [11] = '{32'h20140006, 32'h00140100, 32'h3014000a,
		32'h211c0005, 32'h21240001, 32'h311c0008, 32'h31240002,
		32'h002c00fa, 32'h00340005, 32'h212c0004, 32'h21340002};
	logic [7:0] sc [3] = '{8'h04,8'h08,8'h0c};
	logic sv [3] = '{1'b1,1'b1,1'b0};
	timer8_two_channel timer8_two_channel_i
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_write(reg_write),
		.reg_read(reg_read),
		.reg_rdata(reg_rdata),
		.irq_enable_one(irq_enable_one),
		.sleep_wake(sleep_wake),
		.channel0_out(channel0_out),
		.channel1_out(channel1_out),
		.timer_flag(timer_flag),
		.timer_irq(timer_irq)
	);
	// Clock of 5 ns
	always #2.5 sys_clk = ~sys_clk;
	task automatic check(input string n, input logic [15:0] e,
		input logic [15:0] s);
		check_count++;
		if (s !== e)
		begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	// Read data stand one cycle after the strobe, so compare then
	always @(posedge sys_clk)
	begin
		if (rd_due)
			check($sformatf("reg %h", adr_due), exp_due, reg_rdata & msk_due);
		rd_due <= reg_read;
		exp_due <= exp_now & msk_now;
		msk_due <= msk_now;
		adr_due <= reg_addr;
	end
	// Bus tasks keep the strobe up so accesses may run back to back
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_write <= 1'b1;
		reg_read <= 1'b0;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e,
		input logic [7:0] m);
		reg_read <= 1'b1;
		reg_write <= 1'b0;
		reg_addr <= a;
		exp_now <= e;
		msk_now <= m;
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		reg_read <= 1'b0;
		reg_write <= 1'b0;
		repeat (n) @(posedge sys_clk);
	endtask
	function automatic logic pin(input logic c);
		return c ? channel1_out : channel0_out;
	endfunction
	task automatic hold(input logic c, input logic l, output int n);
		n = 0;
		while (pin(c) === l && n < 600)
		begin
			@(posedge sys_clk);
			n++;
		end
		// A pin that never changes is a mismatch, not a hang
		if (n == 600)
		begin
			check("pin change", 16'h0000, 16'h0258);
			wrap_up();
		end
	endtask
	// Length of one full high phase of a pin, bounded
	task automatic measure(input logic c, input logic [15:0] e);
		int n;
		hold(c, 1'b1, n);
		hold(c, 1'b0, n);
		hold(c, 1'b1, n);
		check("pin high", e, n[15:0]);
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// Main sequence
	initial
	begin
		repeat (16) @(posedge sys_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(ra[i], rv[i], 8'hff);
		wr(8'hca, 8'h55);
		rd(8'hca, 8'h00, 8'hff);
		wr(8'hcf, 8'h01);
		rd(8'hcf, 8'h01, 8'hff);
		wr(8'hcd, 8'h05);
		$display("registers done");
		for (int d = 0; d < 8; d++)
		begin
			wr(8'hcb, {d[2:0], 5'h04});
			wr(8'hcb, {d[2:0], 5'h10});
			idle(4 << d);
			rd(8'hca, 8'h04, 8'hff);
		end
		// Slow start, then the fast rate at once: ten or eleven
		wr(8'hcb, 8'he4);
		wr(8'hcb, 8'hf0);
		idle(3);
		wr(8'hcb, 8'h10);
		idle(10);
		rd(8'hca, 8'h0a, 8'hfe);
		wr(8'hcb, 8'h0c);
		rd(8'hca, 8'h00, 8'hff);
		rd(8'hca, 8'h00, 8'hff);
		rd(8'hcb, 8'h08, 8'hff);
		wr(8'hcb, 8'h10);
		// Divider 0: first read sees the count before the first tick
		rd(8'hca, 8'h00, 8'hff);
		rd(8'hca, 8'h01, 8'hff);
		$display("prescaler done");
		for (int i = 0; i < 11; i++)
		begin
			wr(8'hcb, 8'h0c);
			wr(8'hcc, 8'h00);
			wr(8'hce, 8'h00);
			wr(rows[i][24] ? 8'hce : 8'hcc, rows[i][23:16]);
			wr(8'hcb, {6'h04, rows[i][29:28]});
			idle(1);
			measure(rows[i][24], rows[i][15:0]);
		end
		$display("modes done");
		wr(8'hd8, 8'h07);
		idle(8);
		rd(8'hd8, 8'h04, 8'h04);
		idle(2);
		check("timer_flag", 0, timer_flag);
		wr(8'hce, 8'h74);
		idle(1);
		check("timer_flag", 1, timer_flag);
		for (int i = 0; i < 3; i++)
		begin
			wr(8'hce, sc[i]);
			idle(12);
			check("channel1_out", sv[i], channel1_out);
		end
		$display("actions done");
		wr(8'hcb, 8'h0c);
		wr(8'hd8, 8'h07);
		wr(8'hcb, 8'h19);
		idle(20);
		rd(8'hca, 8'h00, 8'hff);
		rd(8'hd8, 8'h01, 8'h01);
		idle(2);
		check("timer_flag", 1, timer_flag);
		check("timer_irq", 0, timer_irq);
		irq_enable_one <= 1'b1;
		idle(2);
		check("timer_irq", 1, timer_irq);
		$display("down mode done");
		// Wake pulse outlasts the two-flop synchroniser
		sleep_wake <= 1'b1;
		idle(4);
		sleep_wake <= 1'b0;
		rd(8'hcb, 8'h00, 8'h04);
		idle(2);
		$display("wake done");
		wrap_up();
	end
endmodule // tb_top
